// [dpram_pkg.sv]
// Shared constants for the dual-port memory block.
// Assumes a single 50 MHz system clock; no software-visible registers.
package dpram_pkg;
  // Storage size and organisation
  localparam int TOTAL_BITS = 256;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int DEPTH_NIBBLE = 64;
  localparam int DEPTH_BYTE = 32;
  // Organisation select encoding
  localparam logic MODE_NIBBLE = 1'h0;
  localparam logic MODE_BYTE = 1'h1;
  // Edge select encoding
  localparam logic EDGE_RISE = 1'h0;
  localparam logic EDGE_FALL = 1'h1;
  // Reset value of read data
  localparam logic [7:0] READ_DATA_RST = 8'h00;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : dpram_pkg

// [port_clock_detect.sv]
// Synchronises one port clock pin and flags its chosen active edge.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module port_clock_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic falling_sel,
  output logic edge_pulse
);
  import dpram_pkg::*;

  // Three-stage synchroniser; stage 0 feeds only stage 1
  logic [SYNC_STAGES-1:0] sync_reg;
  logic [SYNC_STAGES-1:0] sync_next;
  // Last agreed level of the pin
  logic level_reg;
  logic level_next;
  logic agree;

  // Next state: shift, accept a change once stages 1 and 2 agree
  always_comb begin
    sync_next = {sync_reg[SYNC_STAGES-2:0], pin};
    agree = (sync_reg[1] == sync_reg[2]);
    level_next = agree ? sync_reg[2] : level_reg;
    edge_pulse = 1'b0;
    // Edge only counts when the enable lets state advance
    if (ce && agree && (sync_reg[2] != level_reg)) begin
      edge_pulse = (falling_sel == EDGE_FALL) ? ~sync_reg[2] : sync_reg[2];
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= '0;
      level_reg <= 1'b0;
    end else if (ce) begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end
endmodule : port_clock_detect

// [dual_port_sram_block.sv]
// Dual-port 256-bit memory block, organised 64x4 or 32x8.
// Port clocks arrive as pins, are sampled on clk and act on a chosen edge.
// Behaviour
// [R1] 256 bits, organised 32x8 or 64x4
// [R2] Read and write ports act independently
// [R3] Both addresses six bits, 64 nibbles
// [R4] Byte mode ignores address top bit
// [R5] Per-port clock, selectable active edge
// [R6] 8-bit write input, 8-bit read output
// [R7] User logic may cascade blocks
// [R8] Write on write edge, read on read edge
`timescale 1ns/1ns
module dual_port_sram_block #(
  parameter int DEPTH = dpram_pkg::DEPTH_NIBBLE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic byte_mode,
  input wire logic write_clock,
  input wire logic write_clock_falling,
  input wire logic write_enable,
  input wire logic [dpram_pkg::ADDR_W-1:0] write_address,
  input wire logic [dpram_pkg::DATA_W-1:0] write_data_in,
  input wire logic read_clock,
  input wire logic read_clock_falling,
  input wire logic [dpram_pkg::ADDR_W-1:0] read_address,
  output logic [dpram_pkg::DATA_W-1:0] read_data
);
  import dpram_pkg::*;

  // Nibble-indexed storage, flip-flops
  logic [NIBBLE_W-1:0] mem_reg [DEPTH];
  logic [NIBBLE_W-1:0] mem_next [DEPTH];
  logic [DATA_W-1:0] read_data_reg;
  logic [DATA_W-1:0] read_data_next;
  // Active edges seen on the port clocks
  logic write_edge;
  logic read_edge;
  // Nibble indices for low and high halves
  logic [ADDR_W-1:0] wr_lo;
  logic [ADDR_W-1:0] wr_hi;
  logic [ADDR_W-1:0] rd_lo;
  logic [ADDR_W-1:0] rd_hi;

  // Port pulses under two clk periods per level may be missed
  // [R5] write clock edge
  port_clock_detect write_detect (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(write_clock),
    .falling_sel(write_clock_falling),
    .edge_pulse(write_edge)
  );

  // [R5] read clock edge
  port_clock_detect read_detect (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(read_clock),
    .falling_sel(read_clock_falling),
    .edge_pulse(read_edge)
  );

  // Address mapping per organisation
  always_comb begin
    // [R3] six-bit nibble index
    wr_lo = write_address;
    wr_hi = write_address;
    rd_lo = read_address;
    rd_hi = read_address;
    if (byte_mode == MODE_BYTE) begin
      // [R4] top bit dropped in byte mode
      wr_lo = {write_address[ADDR_W-2:0], 1'b0};
      wr_hi = {write_address[ADDR_W-2:0], 1'b1};
      rd_lo = {read_address[ADDR_W-2:0], 1'b0};
      rd_hi = {read_address[ADDR_W-2:0], 1'b1};
    end
  end

  // Next memory contents
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    // [R8] store on write edge
    if (write_edge && write_enable) begin
      mem_next[wr_lo] = write_data_in[NIBBLE_W-1:0];
      // [R1] byte mode fills a nibble pair
      if (byte_mode == MODE_BYTE) begin
        mem_next[wr_hi] = write_data_in[DATA_W-1:NIBBLE_W];
      end
    end
  end

  // Next read data; reads old contents on a same-cycle collision
  always_comb begin
    read_data_next = read_data_reg;
    // [R2] read independent of write
    if (read_edge) begin
      // [R6] upper half zero in nibble mode
      if (byte_mode == MODE_BYTE) begin
        read_data_next = {mem_reg[rd_hi], mem_reg[rd_lo]};
      end else begin
        read_data_next = {{(DATA_W-NIBBLE_W){1'b0}}, mem_reg[rd_lo]};
      end
    end
  end

  // Memory has no reset, as the real array
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      read_data_reg <= READ_DATA_RST;
    end else if (ce) begin
      read_data_reg <= read_data_next;
    end
  end

  assign read_data = read_data_reg;

  // Write lands at the mapped nibble
  property p_write_store;
    @(posedge clk) disable iff (rst)
      (ce && write_edge && write_enable) |=> (mem_reg[$past(wr_lo)] == $past(write_data_in[3:0]));
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored"); // [R8]

  // Byte mode writes the high nibble too
  property p_byte_write;
    @(posedge clk) disable iff (rst)
      (ce && write_edge && write_enable && byte_mode)
      |=> (mem_reg[$past(wr_hi)] == $past(write_data_in[7:4]));
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("high nibble lost"); // [R1]

  // Read data holds without a read edge
  property p_read_hold;
    @(posedge clk) disable iff (rst)
      (!rst && (!read_edge || !ce)) |=> $stable(read_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved"); // [R8]

  // Nibble mode reads zero on upper lanes
  property p_nibble_upper;
    @(posedge clk) disable iff (rst)
      (ce && read_edge && !byte_mode) |=> (read_data[7:4] == 4'h0);
  endproperty
  a_nibble_upper: assert property (p_nibble_upper) else $error("upper lanes set"); // [R6]

  // Read returns the addressed nibble
  property p_read_value;
    @(posedge clk) disable iff (rst)
      (ce && read_edge) |=> (read_data[3:0] == $past(mem_reg[rd_lo]));
  endproperty
  a_read_value: assert property (p_read_value) else $error("wrong read data"); // [R2]

  // Byte mode ignores address top bit
  property p_addr_top;
    @(posedge clk) disable iff (rst)
      byte_mode |-> (wr_lo[0] == 1'b0 && wr_lo[5:1] == write_address[4:0]);
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("top bit used"); // [R4]

  // Nibble mode indexes all six bits
  property p_addr_full;
    @(posedge clk) disable iff (rst)
      !byte_mode |-> (rd_lo == read_address);
  endproperty
  a_addr_full: assert property (p_addr_full) else $error("address cut"); // [R3]

  // Write edge is a single pulse
  property p_edge_pulse;
    @(posedge clk) disable iff (rst)
      write_edge |=> !write_edge;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge held"); // [R5]

  // Read edge is a single pulse too
  property p_read_pulse;
    @(posedge clk) disable iff (rst)
      read_edge |=> !read_edge;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read edge held"); // [R5]

  // No port edge counts while frozen
  property p_frozen_edges;
    @(posedge clk) disable iff (rst)
      !ce |-> (!write_edge && !read_edge);
  endproperty
  a_frozen_edges: assert property (p_frozen_edges) else $error("edge while frozen"); // [R5]

  // Byte read returns the odd nibble on top
  property p_byte_read;
    @(posedge clk) disable iff (rst)
      (ce && read_edge && byte_mode) |=> (read_data[7:4] == $past(mem_reg[rd_hi]));
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("high read nibble wrong"); // [R6]

  // Disabled write leaves the nibble alone
  property p_write_off;
    @(posedge clk) disable iff (rst)
      (ce && write_edge && !write_enable)
      |=> (mem_reg[$past(wr_lo)] == $past(mem_reg[wr_lo]));
  endproperty
  a_write_off: assert property (p_write_off) else $error("disabled write stored"); // [R8]

  // Byte mode read ignores address top bit
  property p_read_top;
    @(posedge clk) disable iff (rst)
      byte_mode |-> (rd_lo == {read_address[ADDR_W-2:0], 1'b0}
        && rd_hi == {read_address[ADDR_W-2:0], 1'b1});
  endproperty
  a_read_top: assert property (p_read_top) else $error("read top bit used"); // [R4]
endmodule : dual_port_sram_block

// [port_clock_driver.sv]
// Fabric-side model driving one memory port clock pin.
// Assumes go is a one-cycle pulse taken on the rising edge of clk.
`timescale 1ns/1ns
module port_clock_driver (
  input wire logic clk,
  input wire logic go,
  input wire logic falling,
  output logic pin,
  output logic busy
);
  // Pulse sequencer: 5 cycles away from idle, then 5 back
  logic [3:0] step_reg = 4'h0;
  // Starts only from idle, so a go while busy is dropped
  always_ff @(posedge clk) begin
    if (go && step_reg == 4'h0) begin
      step_reg <= 4'h1;
    end else if (step_reg != 4'h0) begin
      step_reg <= (step_reg == 4'ha) ? 4'h0 : step_reg + 4'h1;
    end
  end
  // Idle at the inactive level, so each pulse gives one active edge
  assign pin = falling ^ (step_reg >= 4'h1 && step_reg <= 4'h5);
  assign busy = (step_reg != 4'h0);
endmodule : port_clock_driver

// [tb_dual_port_sram_block.sv]
// Self-checking bench for the dual-port memory block.
// Assumes dpram_pkg and port_clock_driver are compiled first.
`timescale 1ns/1ns
module tb_dual_port_sram_block;
  import dpram_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic byte_mode = 1'b0;
  logic falling = 1'b0;
  logic write_enable = 1'b0;
  logic [5:0] write_address = 6'h00;
  logic [7:0] write_data_in = 8'h00;
  logic [5:0] read_address = 6'h00;
  logic [7:0] read_data;
  logic [7:0] read_data_hi;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic write_clock, read_clock, wr_busy, rd_busy;
  int err_count = 0;
  int checks = 0;
  initial forever #10 clk = ~clk;
  dual_port_sram_block dual_port_sram_block_inst (.clk(clk), .rst(rst), .ce(ce),
    .byte_mode(byte_mode), .write_clock(write_clock), .write_clock_falling(falling),
    .write_enable(write_enable), .write_address(write_address),
    .write_data_in(write_data_in), .read_clock(read_clock),
    .read_clock_falling(falling), .read_address(read_address), .read_data(read_data));
  // Second block side by side on the same inputs mirrors the word
  dual_port_sram_block dual_port_sram_block_hi_inst (.clk(clk), .rst(rst), .ce(ce),
    .byte_mode(byte_mode), .write_clock(write_clock), .write_clock_falling(falling),
    .write_enable(write_enable), .write_address(write_address),
    .write_data_in(write_data_in), .read_clock(read_clock),
    .read_clock_falling(falling), .read_address(read_address), .read_data(read_data_hi));
  port_clock_driver wr_drv (.clk(clk), .go(wr_go), .falling(falling),
    .pin(write_clock), .busy(wr_busy));
  port_clock_driver rd_drv (.clk(clk), .go(rd_go), .falling(falling),
    .pin(read_clock), .busy(rd_busy));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Launch one or both port pulses, wait until both drivers idle
  task automatic pulse(input logic w, input logic r);
    wr_go <= w;
    rd_go <= r;
    @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    do @(negedge clk); while (wr_busy || rd_busy);
    @(posedge clk);
  endtask : pulse
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic we);
    write_address <= a;
    write_data_in <= d;
    write_enable <= we;
    pulse(1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    read_address <= a;
    pulse(1'b0, 1'b1);
    check("read_data", read_data, exp);
    check("cascade read_data", read_data_hi, exp);
  endtask : rd
  task automatic test_nibble;
    wr(6'h00, 8'h1c, 1'b1);
    wr(6'h3f, 8'h07, 1'b1);
    // Disabled write must leave the old nibble
    wr(6'h3f, 8'h09, 1'b0);
    rd(6'h00, 8'h0c);
    rd(6'h3f, 8'h07);
    $display("test nibble done");
  endtask : test_nibble
  task automatic test_byte;
    wr(6'h0a, 8'h05, 1'b1);
    wr(6'h0b, 8'h0a, 1'b1);
    byte_mode <= 1'b1;
    rd(6'h05, 8'ha5);
    // Top address bit set but ignored
    wr(6'h23, 8'h3c, 1'b1);
    rd(6'h03, 8'h3c);
    // Read side ignores the top bit as well
    rd(6'h25, 8'ha5);
    byte_mode <= 1'b0;
    rd(6'h06, 8'h0c);
    rd(6'h07, 8'h03);
    $display("test byte done");
  endtask : test_byte
  task automatic test_falling;
    falling <= 1'b1;
    repeat (4) @(posedge clk);
    wr(6'h14, 8'h0e, 1'b1);
    rd(6'h14, 8'h0e);
    falling <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test falling done");
  endtask : test_falling
  task automatic test_parallel;
    wr(6'h1e, 8'h01, 1'b1);
    write_address <= 6'h15;
    write_data_in <= 8'h06;
    read_address <= 6'h00;
    pulse(1'b1, 1'b1);
    check("parallel read", read_data, 8'h0c);
    rd(6'h15, 8'h06);
    // Same address both ports: old data comes back
    write_address <= 6'h1e;
    write_data_in <= 8'h02;
    read_address <= 6'h1e;
    pulse(1'b1, 1'b1);
    check("collision read", read_data, 8'h01);
    rd(6'h1e, 8'h02);
    $display("test parallel done");
  endtask : test_parallel
  // Enable low freezes both ports; a mid-run reset keeps memory
  task automatic test_hold;
    ce <= 1'b0;
    write_address <= 6'h15;
    write_data_in <= 8'h09;
    read_address <= 6'h00;
    pulse(1'b1, 1'b1);
    check("frozen read_data", read_data, 8'h02);
    ce <= 1'b1;
    rd(6'h15, 8'h06);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("mid reset read_data", read_data, READ_DATA_RST);
    rd(6'h15, 8'h06);
    $display("test hold done");
  endtask : test_hold
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // Watchdog well beyond the roughly 290 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset read_data", read_data, READ_DATA_RST);
    test_nibble;
    test_byte;
    test_falling;
    test_parallel;
    test_hold;
    test_done;
  end
endmodule : tb_dual_port_sram_block
